// ---- hdl/gw_status.sv ----
// Gateway switch decode and front-panel status indicators with an AXI4-Lite slave
//
// How it works
// - Node address is ten times tens plus units
// - Codes 5-8 give 250k..1M, 9 reserved
// - Switches captured once, only at startup
// - Run: flash stopped, blink preop, on operational
// - Error: off, flash1/2/3 by cause, on bus-off
// - Status red on unrecoverable fault, else dark
// - Subnet green once all configured transactions active
// - Subnet red on timeout/stop, green blinking after errors
// - Device: alternate, green, blinking green, red per condition
// - At most thirty-one serial nodes addressed
// - Up to eighty receive and transmit PDOs
`timescale 1ns/100ps
module gw_status
  import gw_status_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Rotary selectors
  input wire logic [3:0] sw_units_in,
  input wire logic [3:0] sw_tens_in,
  input wire logic [3:0] sw_rate_in,
  // Subnet transaction events
  input wire logic [31:0] trans_active_in,
  input wire logic [31:0] trans_error_in,
  input wire logic [31:0] trans_timeout_in,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded settings
  output logic [6:0] node_addr_out,
  output logic [10:0] bit_rate_out,
  output logic rate_valid_out,
  // Indicators
  output logic run_led_out,
  output logic err_led_out,
  output logic status_red_out,
  output bicolor_t subnet_led_out,
  output bicolor_t device_led_out
);

  // Startup capture sequencer
  // One-hot codes; the default arm only catches a corrupted state
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } boot_t;
  boot_t boot_reg;

  // Software-written control and subnet configuration
  logic [31:0] ctrl_reg;
  logic [31:0] cfg_mask_reg;
  logic [31:0] seen_reg; // Transactions seen active since clear
  logic err_seen_reg; // Some transaction has failed
  logic timeout_reg; // Some transaction timed out

  // Timebase and pattern levels
  // Divider is wide enough for one millisecond at the system clock
  logic [17:0] div_reg;
  logic tick_reg;
  logic blink_lvl;
  logic [2:0] flash_lvl;

  // Bus handshake state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] rd_next;
  logic rd_ok_next;

  // Control fields
  // Fields are plain slices of the control word, decoded where used
  logic [1:0] nmt_state;
  logic [2:0] bus_err;
  logic fault_flag;
  logic [1:0] dev_cond;
  logic subnet_stop;
  assign nmt_state = ctrl_reg[CTRL_NMT_LSB +: 2];
  assign bus_err = ctrl_reg[CTRL_ERR_LSB +: 3];
  assign fault_flag = ctrl_reg[CTRL_FAULT_BIT];
  assign dev_cond = ctrl_reg[CTRL_DEV_LSB +: 2];
  assign subnet_stop = ctrl_reg[CTRL_STOP_BIT];

  // Only node slots 1..31 exist on the serial side; bit 0 is never configured
  // An empty mask never lights green, though the state register still reads it as all seen
  logic [31:0] cfg_valid;
  assign cfg_valid = {cfg_mask_reg[31:1], 1'b0};

  // Divider giving a one-cycle millisecond tick
  // The only slower rate in the block is this enable, never a second clock
  // Flash patterns start in their lit phase and blink starts dark, so a flash shows at once
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      div_reg <= 18'h00000;
      tick_reg <= 1'b0;
    end else if (div_reg == 18'(TICK_CYCLES - 1)) begin
      div_reg <= 18'h00000;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 18'h00001;
      tick_reg <= 1'b0;
    end
  end

  // One shared pattern source keeps all indicators in step
  flash_gen u_flash (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .tick_in(tick_reg),
    .blink_out(blink_lvl),
    .flash_out(flash_lvl)
  );

  // Switches are sampled in the first cycle after reset and then frozen
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      boot_reg <= ST_CAPTURE;
      node_addr_out <= 7'h00;
      bit_rate_out <= RATE_RSVD;
      rate_valid_out <= 1'b0;
    end else begin
      unique case (boot_reg)
        ST_CAPTURE: begin
          // Clocked capture after release; later switch moves are ignored
          // Operands widened first so the product keeps all seven bits
          // Digits above nine give no defined address; they are not refused
          node_addr_out <= ({3'h0, sw_tens_in} * {3'h0, ADDR_SCALE}) + {3'h0, sw_units_in};
          rate_valid_out <= 1'b1;
          unique case (sw_rate_in)
            4'h1: bit_rate_out <= RATE_10K;
            4'h2: bit_rate_out <= RATE_20K;
            4'h3: bit_rate_out <= RATE_50K;
            4'h4: bit_rate_out <= RATE_125K;
            4'h5: bit_rate_out <= RATE_250K;
            4'h6: bit_rate_out <= RATE_500K;
            4'h7: bit_rate_out <= RATE_800K;
            4'h8: bit_rate_out <= RATE_1M;
            default: begin
              // Codes 0, 9 and above are reserved
              // A reserved code leaves the rate invalid until restart
              bit_rate_out <= RATE_RSVD;
              rate_valid_out <= 1'b0;
            end
          endcase
          boot_reg <= ST_RUN;
        end
        ST_RUN: boot_reg <= ST_RUN;
        default: boot_reg <= ST_CAPTURE;
      endcase
    end
  end

  // Transaction history; events win over a software clear in the same cycle
  // Writing the subnet mask restarts the watch for a fresh setup
  // Flags are sticky until then; only configured slots are recorded
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      seen_reg <= 32'h0000_0000;
      err_seen_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      if (w_held_reg && aw_held_reg && awaddr_reg == SUBNET_ADDR) begin
        seen_reg <= trans_active_in & cfg_valid;
        err_seen_reg <= |(trans_error_in & cfg_valid);
        timeout_reg <= |(trans_timeout_in & cfg_valid);
      end else begin
        seen_reg <= seen_reg | (trans_active_in & cfg_valid);
        err_seen_reg <= err_seen_reg | (|(trans_error_in & cfg_valid));
        timeout_reg <= timeout_reg | (|(trans_timeout_in & cfg_valid));
      end
    end
  end

  // Run and error indicators
  // Both follow the pattern levels one clock late, far below what an eye sees
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      run_led_out <= 1'b0;
      err_led_out <= 1'b0;
    end else begin
      unique case (nmt_state)
        NMT_STOPPED: run_led_out <= flash_lvl[0];
        NMT_PREOP: run_led_out <= blink_lvl;
        NMT_OPER: run_led_out <= 1'b1;
        NMT_INIT: run_led_out <= 1'b0;
      endcase
      case (bus_err)
        BERR_WARN: err_led_out <= flash_lvl[0];
        BERR_ECTRL: err_led_out <= flash_lvl[1];
        BERR_SYNC: err_led_out <= flash_lvl[2];
        BERR_BUSOFF: err_led_out <= 1'b1;
        default: err_led_out <= 1'b0; // No error or unused code
      endcase
    end
  end

  // Module status, subnet and device indicators
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      status_red_out <= 1'b0;
      subnet_led_out <= '0;
      device_led_out <= '0;
    end else begin
      status_red_out <= fault_flag;
      // Red has priority: a timeout or stop overrides any green state
      if (timeout_reg || subnet_stop) begin
        subnet_led_out <= '{red: 1'b1, green: 1'b0};
      end else if ((seen_reg & cfg_valid) == cfg_valid && cfg_valid != 32'h0) begin
        subnet_led_out <= '{red: 1'b0, green: err_seen_reg ? blink_lvl : 1'b1};
      end else begin
        subnet_led_out <= '0;
      end
      // Device colour is fixed or follows the blink level
      unique case (dev_cond)
        DEV_BADCFG: device_led_out <= '{red: blink_lvl, green: ~blink_lvl};
        DEV_INIT: device_led_out <= '{red: 1'b0, green: 1'b1};
        DEV_RUN: device_led_out <= '{red: 1'b0, green: blink_lvl};
        DEV_BOOT: device_led_out <= '{red: 1'b1, green: 1'b0};
      endcase
    end
  end

  // Write channel: address and data taken in either order, response after both
  // Readies toggle, so a taken item drops ready without extra logic
  // Readies stay low while a response waits, one write at a time
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_reg <= CTRL_RESET;
      cfg_mask_reg <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held_reg && w_held_reg) begin
        // Commit the write and answer; unmapped or read-only offsets give SLVERR
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b10;
        if (awaddr_reg == CTRL_ADDR) begin
          for (int i = 0; i < 4; i++) begin
            if (wstrb_reg[i]) ctrl_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
          end
          s_axi_bresp <= 2'b00;
        end else if (awaddr_reg == SUBNET_ADDR) begin
          for (int i = 0; i < 4; i++) begin
            if (wstrb_reg[i]) cfg_mask_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
          end
          s_axi_bresp <= 2'b00;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  // Decoded from the live address so data is ready at the accept edge
  // Unmapped offsets read zero and answer SLVERR
  always_comb begin
    rd_next = 32'h0000_0000;
    rd_ok_next = 1'b1;
    case (s_axi_araddr)
      CTRL_ADDR: rd_next = ctrl_reg;
      SUBNET_ADDR: rd_next = cfg_mask_reg;
      STATE_ADDR: rd_next = {29'h0, timeout_reg, err_seen_reg, (seen_reg & cfg_valid) == cfg_valid};
      SWITCH_ADDR: rd_next = {12'h0, rate_valid_out, bit_rate_out, 1'b0, node_addr_out};
      LED_ADDR: rd_next = {25'h0, device_led_out, subnet_led_out, status_red_out, err_led_out, run_led_out};
      CAP_ADDR: rd_next = {9'h0, MAX_PDOS, 1'b0, MAX_PDOS, 3'h0, MAX_NODES};
      default: rd_ok_next = 1'b0;
    endcase
  end

  // Read channel: one-cycle accept, data one cycle later, held until taken
  // Reads share no state with writes, so the two may overlap
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_next;
        s_axi_rresp <= rd_ok_next ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- hdl/gw_status_pkg.sv ----
// Package holding constants and types of the gateway status and switch decode block
package gw_status_pkg;

  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATE_ADDR = 8'h04;
  localparam logic [7:0] SUBNET_ADDR = 8'h08;
  localparam logic [7:0] SWITCH_ADDR = 8'h0c;
  localparam logic [7:0] LED_ADDR = 8'h10;
  localparam logic [7:0] CAP_ADDR = 8'h14;

  // Control register field positions
  localparam int CTRL_NMT_LSB = 0;
  localparam int CTRL_ERR_LSB = 4;
  localparam int CTRL_FAULT_BIT = 8;
  localparam int CTRL_DEV_LSB = 12;
  localparam int CTRL_STOP_BIT = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Subnet register fields
  localparam int SUB_CFG_LSB = 0;
  localparam int SUB_ACT_LSB = 32;
  localparam logic [4:0] MAX_NODES = 5'h1f;
  localparam logic [6:0] MAX_PDOS = 7'h50;
  localparam logic [3:0] ADDR_SCALE = 4'ha;

  // Fieldbus node state codes
  localparam logic [1:0] NMT_INIT = 2'h0;
  localparam logic [1:0] NMT_STOPPED = 2'h1;
  localparam logic [1:0] NMT_PREOP = 2'h2;
  localparam logic [1:0] NMT_OPER = 2'h3;

  // Bus error codes
  localparam logic [2:0] BERR_NONE = 3'h0;
  localparam logic [2:0] BERR_WARN = 3'h1;
  localparam logic [2:0] BERR_ECTRL = 3'h2;
  localparam logic [2:0] BERR_SYNC = 3'h3;
  localparam logic [2:0] BERR_BUSOFF = 3'h4;

  // Device condition codes
  localparam logic [1:0] DEV_BADCFG = 2'h0;
  localparam logic [1:0] DEV_INIT = 2'h1;
  localparam logic [1:0] DEV_RUN = 2'h2;
  localparam logic [1:0] DEV_BOOT = 2'h3;

  // Bit-rate codes in kbit/s
  localparam logic [10:0] RATE_RSVD = 11'h000;
  localparam logic [10:0] RATE_10K = 11'h00a;
  localparam logic [10:0] RATE_20K = 11'h014;
  localparam logic [10:0] RATE_50K = 11'h032;
  localparam logic [10:0] RATE_125K = 11'h07d;
  localparam logic [10:0] RATE_250K = 11'h0fa;
  localparam logic [10:0] RATE_500K = 11'h1f4;
  localparam logic [10:0] RATE_800K = 11'h320;
  localparam logic [10:0] RATE_1M = 11'h3e8;

  // Flash timing: 200 ms on and off, 1000 ms gap, from a 1 ms tick
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int FLASH_MS = 200;
  localparam int GAP_MS = 1000;
  localparam int BLINK_MS = 200;

  // Indicator pattern selects
  localparam logic [2:0] PAT_OFF = 3'h0;
  localparam logic [2:0] PAT_ON = 3'h1;
  localparam logic [2:0] PAT_BLINK = 3'h2;
  localparam logic [2:0] PAT_F1 = 3'h3;
  localparam logic [2:0] PAT_F2 = 3'h4;
  localparam logic [2:0] PAT_F3 = 3'h5;

  // Red and green pair for a bicolour indicator
  typedef struct packed {
    logic red;
    logic green;
  } bicolor_t;

endpackage

// ---- hdl/flash_gen.sv ----
// Flash pattern generator giving blink and single, double and triple flash levels
`timescale 1ns/100ps
module flash_gen
  import gw_status_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Timebase
  input wire logic tick_in,
  // Pattern levels
  output logic blink_out,
  output logic [2:0] flash_out
);

  // Phase within a flash sequence, in ticks
  localparam int SEQ_MS = 5 * FLASH_MS + GAP_MS;
  logic [11:0] ms_reg;
  logic [7:0] blink_reg;

  // Sequence counter wraps after three flashes plus the long gap
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ms_reg <= 12'h000;
    end else if (tick_in) begin
      if (ms_reg == 12'(SEQ_MS - 1)) begin
        ms_reg <= 12'h000;
      end else begin
        ms_reg <= ms_reg + 12'h001;
      end
    end
  end

  // Blink is an even on/off square wave
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      blink_reg <= 8'h00;
      blink_out <= 1'b0;
    end else if (tick_in) begin
      if (blink_reg == 8'(BLINK_MS - 1)) begin
        blink_reg <= 8'h00;
        blink_out <= ~blink_out;
      end else begin
        blink_reg <= blink_reg + 8'h01;
      end
    end
  end

  // Flash n is lit in the first n on-slots, each slot one flash period, then dark
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      flash_out <= 3'h0;
    end else begin
      flash_out[0] <= ms_reg < 12'(FLASH_MS);
      flash_out[1] <= ms_reg < 12'(FLASH_MS) ||
                      (ms_reg >= 12'(2 * FLASH_MS) && ms_reg < 12'(3 * FLASH_MS));
      flash_out[2] <= ms_reg < 12'(FLASH_MS) ||
                      (ms_reg >= 12'(2 * FLASH_MS) && ms_reg < 12'(3 * FLASH_MS)) ||
                      (ms_reg >= 12'(4 * FLASH_MS) && ms_reg < 12'(5 * FLASH_MS));
    end
  end

endmodule

// ---- verif/gw_status_props.sv ----
// Concurrent checks on the ports of the gateway status block
`timescale 1ns/100ps
module gw_status_props
  import gw_status_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Selectors and subnet events
  input wire logic [3:0] sw_units_in,
  input wire logic [3:0] sw_tens_in,
  input wire logic [3:0] sw_rate_in,
  input wire logic [31:0] trans_timeout_in,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded outputs
  input wire logic [6:0] node_addr_out,
  input wire logic [10:0] bit_rate_out,
  input wire logic rate_valid_out,
  input wire bicolor_t subnet_led_out
);
  // Expected rate per selector code, zero where reserved
  localparam logic [10:0] RATE_TAB [16] = '{0: 11'h000, 1: 11'h00a, 2: 11'h014, 3: 11'h032, 4: 11'h07d,
    5: 11'h0fa, 6: 11'h1f4, 7: 11'h320, 8: 11'h3e8, default: 11'h000};

  // One clock domain, so one default clock and reset
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  AST_ADDR: assert property ($rose(nrst_in) |=> node_addr_out ==
    {3'h0, $past(sw_tens_in)} * 7'h0a + {3'h0, $past(sw_units_in)}) else $error("node address wrong");
  AST_RATE: assert property ($rose(nrst_in) |=> bit_rate_out == RATE_TAB[$past(sw_rate_in)] &&
    rate_valid_out == (bit_rate_out != 11'h000)) else $error("bit rate decode wrong");
  // Once captured, selector moves must not reach the outputs
  AST_HOLD: assert property (nrst_in && $past(nrst_in) && $past(nrst_in, 2) |->
    $stable(node_addr_out) && $stable(bit_rate_out) && $stable(rate_valid_out)) else $error("settings moved");
  AST_SUB_TMO: assert property (|trans_timeout_in[31:1] |-> ##[1:3] subnet_led_out.red)
    else $error("subnet not red on timeout");
  AST_BRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  AST_BDROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_NORDY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  AST_RV: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  AST_RDROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  AST_RZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");

  // Main scenarios reached
  COV_START: cover property ($rose(nrst_in));
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_TMO: cover property (subnet_led_out.red);
endmodule

bind gw_status gw_status_props chk (.sys_clk_in, .nrst_in, .sw_units_in, .sw_tens_in, .sw_rate_in,
  .trans_timeout_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .node_addr_out, .bit_rate_out, .rate_valid_out, .subnet_led_out);

// ---- verif/subnet_node_model.sv ----
// Model of the serial subnet nodes reporting transaction events
`timescale 1ns/100ps
module subnet_node_model (
  // Clock
  input wire logic sys_clk_in,
  // Event request from the bench
  input wire logic go_in,
  input wire logic [1:0] kind_in,
  input wire logic [4:0] slot_in,
  // Per-slot event pulses
  output logic [31:0] active_out,
  output logic [31:0] error_out,
  output logic [31:0] timeout_out
);
  // One-cycle pulse on one slot; slot 0 is no node, so it never fires
  always_ff @(posedge sys_clk_in) begin
    active_out <= 32'h0;
    error_out <= 32'h0;
    timeout_out <= 32'h0;
    if (go_in && slot_in != 5'h0) begin
      case (kind_in)
        2'h0: active_out[slot_in] <= 1'b1;
        2'h1: error_out[slot_in] <= 1'b1;
        default: timeout_out[slot_in] <= 1'b1;
      endcase
    end
  end
endmodule

// ---- verif/gw_status_test.sv ----
// Self-checking bench for the gateway status block
`timescale 1ns/100ps
module gw_status_test;
  import gw_status_pkg::*;
  // Expected bus answer, noted by the driver
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
    logic [31:0] mask;
  } note_t;
  note_t notes[$];
  int mismatches = 0;
  int comparisons = 0;
  integer seed = 32'hcf18;
  int t, u, j, i;
  // Expected kbit/s per selector code
  logic [31:0] kb [16] = '{0: 32'h0, 1: 32'ha, 2: 32'h14, 3: 32'h32, 4: 32'h7d, 5: 32'hfa, 6: 32'h1f4,
    7: 32'h320, 8: 32'h3e8, default: 32'h0};
  // Design inputs, all valued at time zero
  logic sys_clk_in = 1'b0, nrst_in = 1'b0;
  logic [3:0] sw_units_in = 4'h0, sw_tens_in = 4'h0, sw_rate_in = 4'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [4:0] slot = 5'h0;
  // Design outputs and model pulses
  logic [31:0] trans_active_in, trans_error_in, trans_timeout_in, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rate_valid_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] node_addr_out;
  logic [10:0] bit_rate_out;
  logic run_led_out, err_led_out, status_red_out;
  bicolor_t subnet_led_out, device_led_out;

  // 250 MHz clock
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  gw_status dut (.sys_clk_in, .nrst_in, .sw_units_in, .sw_tens_in, .sw_rate_in, .trans_active_in,
    .trans_error_in, .trans_timeout_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .node_addr_out, .bit_rate_out, .rate_valid_out, .run_led_out, .err_led_out, .status_red_out,
    .subnet_led_out, .device_led_out);
  subnet_node_model nodes (.sys_clk_in, .go_in(go), .kind_in(kind), .slot_in(slot),
    .active_out(trans_active_in), .error_out(trans_error_in), .timeout_out(trans_timeout_in));

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Match each bus answer against the oldest note
  task automatic take(input logic [1:0] resp, input logic [31:0] data);
    note_t n;
    if (notes.size() == 0) begin
      check("unexpected answer", 32'h1, 32'h0);
    end else begin
      n = notes.pop_front();
      check("resp", {30'h0, resp}, {30'h0, n.resp});
      check("rdata", data & n.mask, n.data & n.mask);
    end
  endtask

  // Watcher of the two response channels
  always @(posedge sys_clk_in) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) take(s_axi_bresp, 32'h0);
    if (s_axi_rvalid === 1'b1 && s_axi_rready) take(s_axi_rresp, s_axi_rdata);
  end

  // Reset pulse, then time for the selector capture
  task automatic rst(input int n);
    nrst_in <= 1'b0;
    repeat (n) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
  endtask

  // Bounded wait ran out
  task automatic hang();
    mismatches++;
    final_report();
  endtask

  // Bus write; address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    notes.push_back('{r, 32'h0, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && (n == 0 || s_axi_awvalid || s_axi_wvalid || s_axi_bready); n++) begin
      @(posedge sys_clk_in);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bready <= 1'b0;
    end
    if (n >= 100) hang();
  endtask

  // Bus read with masked expectation
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    int n;
    notes.push_back('{r, d, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && (n == 0 || s_axi_arvalid || s_axi_rready); n++) begin
      @(posedge sys_clk_in);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) s_axi_rready <= 1'b0;
    end
    if (n >= 100) hang();
  endtask

  // Ask the node model for one event; indicators lag a couple of cycles
  task automatic evt(input logic [1:0] k, input logic [4:0] s);
    kind <= k;
    slot <= s;
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask

  // Main sequence
  initial begin
    // Every rate code, random address digits, one restart each; ends on code 8
    for (j = 0; j < 16; j++) begin
      i = (j + 9) % 16;
      t = $unsigned($random(seed)) % 10;
      u = $unsigned($random(seed)) % 10;
      sw_tens_in <= 4'(t);
      sw_units_in <= 4'(u);
      sw_rate_in <= 4'(i);
      rst(j == 0 ? 20 : 2);
      check("node_addr", {25'h0, node_addr_out}, 32'(t * 10 + u));
      check("bit_rate", {21'h0, bit_rate_out}, kb[i]);
      check("rate_valid", {31'h0, rate_valid_out}, {31'h0, kb[i] != 32'h0});
    end
    // Selector moves while running have no effect
    sw_tens_in <= ~sw_tens_in;
    sw_rate_in <= 4'h1;
    repeat (5) @(posedge sys_clk_in);
    check("held addr", {25'h0, node_addr_out}, 32'(t * 10 + u));
    axr(SWITCH_ADDR, {12'h1, 11'h3e8, 1'b0, 7'(t * 10 + u)}, 32'h000f_ff7f, 2'h0);
    $display("selector test done");
    // Capacity, unmapped read, refused write to a read-only place
    axr(CAP_ADDR, 32'h0050_501f, 32'h007f_7f1f, 2'h0);
    axr(8'h18, 32'h0, 32'hffff_ffff, 2'h2);
    axw(CAP_ADDR, 32'h0, 2'h2);
    axr(CAP_ADDR, 32'h0050_501f, 32'h007f_7f1f, 2'h0);
    $display("register test done");
    // Steady indicator levels: operational, bus off, fault, bootloader, subnet stop
    axw(CTRL_ADDR, 32'h0001_3143, 2'h0);
    repeat (2) @(posedge sys_clk_in);
    axr(LED_ADDR, 32'h57, 32'h7f, 2'h0);
    axr(CTRL_ADDR, 32'h0001_3143, 32'h0001_3173, 2'h0);
    // Initial state, no error, no fault, initializing
    axw(CTRL_ADDR, 32'h0000_1000, 2'h0);
    repeat (2) @(posedge sys_clk_in);
    axr(LED_ADDR, 32'h20, 32'h7f, 2'h0);
    // Stopped, sync error, bad configuration: flashes start lit, blink starts dark
    axw(CTRL_ADDR, 32'h0000_0031, 2'h0);
    axr(LED_ADDR, 32'h23, 32'h7f, 2'h0);
    $display("indicator test done");
    // Slots 1 and 2 configured; green only once both were active
    axw(SUBNET_ADDR, 32'h6, 2'h0);
    evt(2'h0, 5'h1);
    axr(LED_ADDR, 32'h0, 32'h18, 2'h0);
    evt(2'h0, 5'h2);
    axr(LED_ADDR, 32'h08, 32'h18, 2'h0);
    evt(2'h2, 5'h1);
    axr(LED_ADDR, 32'h10, 32'h18, 2'h0);
    axr(STATE_ADDR, 32'h5, 32'h5, 2'h0);
    // Fresh history, then a transaction error: not red
    axw(SUBNET_ADDR, 32'h6, 2'h0);
    evt(2'h1, 5'h2);
    axr(STATE_ADDR, 32'h2, 32'h7, 2'h0);
    axr(LED_ADDR, 32'h0, 32'h10, 2'h0);
    $display("subnet test done");
    check("notes left", notes.size(), 32'h0);
    final_report();
  end
endmodule
